// ---- tsu_touch_control.sv ----
// Touch sense unit: register file, acquisition sequencer and pulse generator
`timescale 1ns/1ps
`include "tsu_cfg.svh"

module tsu_touch_control
    import tsu_pkg::*;
#(
    parameter int GROUPS = 6,
    parameter int PINS = 24
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Sync input and group threshold inputs
    input wire logic sync_in,
    input wire logic [GROUPS-1:0] group_threshold,
    // Sensing pins
    output logic charge_pulse,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe_n,
    output logic acquiring,
    // Interrupt
    output logic irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] touch_control;
    logic [1:0] touch_irq_enable;
    logic [1:0] touch_irq_status;
    logic [PINS-1:0] pin_hysteresis_control;
    logic [PINS-1:0] pin_analog_switch_control;
    logic [PINS-1:0] pin_sampling_control;
    logic [PINS-1:0] pin_channel_control;
    logic [GROUPS-1:0] group_enable;
    logic [GROUPS-1:0] group_done;
    logic [13:0] group_pulse_count [GROUPS];
    tsu_state_t state;
    logic [13:0] pulse_count;
    logic [7:0] pre_count;
    logic [6:0] phase_count;
    logic [15:0] lfsr;
    logic sync_prev;
    logic done_event;
    logic ovf_event;

    // Control fields
    logic unit_enable;
    logic acquire_start;
    logic acquire_mode_select;
    logic sync_polarity;
    logic idle_pin_state;
    logic [2:0] count_limit_select;
    logic [2:0] pulse_clock_divider;
    logic spread_clock_divider;
    logic spread_enable;
    logic [6:0] spread_deviation_select;
    logic [3:0] pulse_low_length;
    logic [3:0] pulse_high_length;
    assign unit_enable = touch_control[`TSU_BIT_ENABLE];
    assign acquire_start = touch_control[`TSU_BIT_START];
    assign acquire_mode_select = touch_control[`TSU_BIT_MODE];
    assign sync_polarity = touch_control[`TSU_BIT_POLARITY];
    assign idle_pin_state = touch_control[`TSU_BIT_IDLE];
    assign count_limit_select = touch_control[`TSU_LIMIT_MSB:`TSU_LIMIT_LSB];
    assign pulse_clock_divider = touch_control[`TSU_PDIV_MSB:`TSU_PDIV_LSB];
    assign spread_clock_divider = touch_control[`TSU_BIT_SDIV];
    assign spread_enable = touch_control[`TSU_BIT_SPREAD];
    assign spread_deviation_select = touch_control[`TSU_DEV_MSB:`TSU_DEV_LSB];
    assign pulse_low_length = touch_control[`TSU_LOW_MSB:`TSU_LOW_LSB];
    assign pulse_high_length = touch_control[`TSU_HIGH_MSB:`TSU_HIGH_LSB];

    // ----------------------------------------------------------------
    // Derived timing
    // ----------------------------------------------------------------
    logic [13:0] count_limit;
    logic [7:0] pre_limit;
    logic pg_tick;
    logic ss_tick;
    logic sync_event;
    logic all_done;
    logic limit_hit;
    logic [7:0] spread_len;
    logic ss_phase;

    assign count_limit = 14'((15'h00FF << count_limit_select) | 15'h00FF);
    // divide by two to the field value
    assign pre_limit = 8'((9'h001 << pulse_clock_divider) - 9'h001);
    assign pg_tick = (pre_count == pre_limit);
    // spread clock is every cycle or every second
    // Own toggle, as the prescaler is held during the spread phase
    assign ss_tick = spread_clock_divider ? ss_phase : 1'b1;
    // falling edge, or rising edge and high level
    // Level mode fires on any high sample after the start
    assign sync_event = sync_polarity ? (sync_in & ~sync_prev) | (sync_in & sync_prev) : (~sync_in & sync_prev);
    assign all_done = &(group_done | ~group_enable);
    // reserved code never overflows
    // Count after this pulse, so the limit pulse itself overflows
    assign limit_hit = (count_limit_select != `TSU_LIMIT_RESERVED) && ((pulse_count + 14'h0001) >= count_limit);
    // random insertion of 0 up to field plus one periods
    assign spread_len = 8'(lfsr[7:0] % (8'(spread_deviation_select) + 8'h02));

    // ----------------------------------------------------------------
    // Acquisition sequencer
    // ----------------------------------------------------------------
    // disabled unit stays idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= TSU_IDLE;
            phase_count <= 7'h00;
            pulse_count <= 14'h0000;
            done_event <= 1'b0;
            ovf_event <= 1'b0;
        end else begin
            done_event <= 1'b0;
            ovf_event <= 1'b0;
            if (!unit_enable) begin
                state <= TSU_IDLE;
            end else begin
                case (state)
                    TSU_IDLE: begin
                        phase_count <= 7'h00;
                        pulse_count <= 14'h0000;
                        // mode selects gating
                        // Start still reads set in the cycle after done
                        if (acquire_start && !done_event) begin
                            state <= acquire_mode_select ? TSU_WAIT_SYNC : TSU_HIGH;
                        end
                    end
                    TSU_WAIT_SYNC: begin
                        if (sync_event) begin
                            state <= TSU_HIGH;
                        end
                    end
                    TSU_HIGH: begin
                        if (pg_tick) begin
                            if (phase_count == 7'(pulse_high_length)) begin
                                phase_count <= 7'h00;
                                state <= (spread_enable && spread_len != 8'h00) ? TSU_SPREAD : TSU_LOW;
                            end else begin
                                phase_count <= phase_count + 7'h01;
                            end
                        end
                    end
                    TSU_SPREAD: begin
                        if (ss_tick) begin
                            // Length holds steady here, the dither steps in the low phase
                            if (8'(phase_count) >= spread_len - 8'h01) begin
                                phase_count <= 7'h00;
                                state <= TSU_LOW;
                            end else begin
                                phase_count <= phase_count + 7'h01;
                            end
                        end
                    end
                    TSU_LOW: begin
                        if (pg_tick) begin
                            if (phase_count == 7'(pulse_low_length)) begin
                                phase_count <= 7'h00;
                                pulse_count <= pulse_count + 14'h0001;
                                if (limit_hit) begin
                                    ovf_event <= 1'b1;
                                    done_event <= 1'b1;
                                    state <= TSU_IDLE;
                                end else if (all_done) begin
                                    done_event <= 1'b1;
                                    state <= TSU_IDLE;
                                end else begin
                                    state <= TSU_HIGH;
                                end
                            end else begin
                                phase_count <= phase_count + 7'h01;
                            end
                        end
                    end
                    default: begin
                        state <= TSU_IDLE;
                    end
                endcase
            end
        end
    end

    // Prescaler runs in the high and low phases only
    // Held in spread, so the low phase starts on a whole period
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre_count <= 8'h00;
        end else if (state == TSU_IDLE || state == TSU_WAIT_SYNC || state == TSU_SPREAD || pg_tick) begin
            pre_count <= 8'h00;
        end else begin
            pre_count <= pre_count + 8'h01;
        end
    end

    // half-rate spread tick, restarted on entry to the spread phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ss_phase <= 1'b0;
        end else begin
            ss_phase <= (state == TSU_SPREAD) ? ~ss_phase : 1'b0;
        end
    end

    // Sync history and dither source
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync_prev <= 1'b0;
            lfsr <= `TSU_LFSR_SEED;
        end else begin
            sync_prev <= sync_in;
            // Stepped in the low phase so the spread length holds through high and spread
            if (state == TSU_LOW && pg_tick) begin
                lfsr <= {1'b0, lfsr[15:1]} ^ (lfsr[0] ? `TSU_LFSR_TAPS : 16'h0000);
            end
        end
    end

    // ----------------------------------------------------------------
    // Group counters: latch pulse count on threshold
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : gen_group
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    group_done[g] <= 1'b0;
                    group_pulse_count[g] <= 14'h0000;
                // Same start condition as the sequencer
                end else if (state == TSU_IDLE && acquire_start && unit_enable && !done_event) begin
                    group_done[g] <= 1'b0;
                end else if (state == TSU_LOW && group_enable[g] && !group_done[g] && group_threshold[g]) begin
                    group_done[g] <= 1'b1;
                    group_pulse_count[g] <= pulse_count;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // start cleared by hardware at end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            touch_control <= `TSU_RST_ZERO;
        end else begin
            if (reg_write && reg_addr == `TSU_OFF_CONTROL) begin
                touch_control <= reg_wdata & `TSU_CONTROL_MASK;
            end
            if (done_event) begin
                touch_control[`TSU_BIT_START] <= 1'b0;
            end
        end
    end

    // Pin and group configuration
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            touch_irq_enable <= 2'h0;
            pin_hysteresis_control <= PINS'(`TSU_RST_HYSTERESIS);
            pin_analog_switch_control <= '0;
            pin_sampling_control <= '0;
            pin_channel_control <= '0;
            group_enable <= '0;
        end else if (reg_write) begin
            case (reg_addr)
                `TSU_OFF_IRQ_ENABLE: touch_irq_enable <= reg_wdata[1:0];
                `TSU_OFF_HYSTERESIS: pin_hysteresis_control <= PINS'(reg_wdata);
                `TSU_OFF_ANALOG_SWITCH: pin_analog_switch_control <= PINS'(reg_wdata);
                `TSU_OFF_SAMPLING: pin_sampling_control <= PINS'(reg_wdata);
                `TSU_OFF_CHANNEL: pin_channel_control <= PINS'(reg_wdata);
                `TSU_OFF_GROUP_STATUS: group_enable <= GROUPS'(reg_wdata);
                default: begin
                end
            endcase
        end
    end

    // Sticky flags: set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            touch_irq_status <= 2'h0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if ((b == `TSU_BIT_DONE && done_event) || (b == `TSU_BIT_OVF && ovf_event)) begin
                    touch_irq_status[b] <= 1'b1;
                end else if ((reg_write && reg_addr == `TSU_OFF_FLAG_CLEAR && reg_wdata[b]) ||
                             (reg_read && reg_addr == `TSU_OFF_IRQ_STATUS)) begin
                    touch_irq_status[b] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads, one cycle later; unmapped reads zero
    // ----------------------------------------------------------------
    // offset decode, group counts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `TSU_RST_ZERO;
        end else if (reg_read) begin
            reg_rdata <= `TSU_RST_ZERO;
            case (reg_addr)
                `TSU_OFF_CONTROL: reg_rdata <= touch_control;
                `TSU_OFF_IRQ_ENABLE: reg_rdata <= {30'h0, touch_irq_enable};
                `TSU_OFF_IRQ_STATUS: reg_rdata <= {30'h0, touch_irq_status};
                `TSU_OFF_HYSTERESIS: reg_rdata <= 32'(pin_hysteresis_control);
                `TSU_OFF_ANALOG_SWITCH: reg_rdata <= 32'(pin_analog_switch_control);
                `TSU_OFF_SAMPLING: reg_rdata <= 32'(pin_sampling_control);
                `TSU_OFF_CHANNEL: reg_rdata <= 32'(pin_channel_control);
                `TSU_OFF_GROUP_STATUS: reg_rdata <= {8'h00, 8'(group_done), 8'h00, 8'(group_enable)};
                default: begin
                    // Group counts follow the group status word, one word each
                    for (int k = 1; k <= GROUPS; k++) begin
                        if (reg_addr == 8'(`TSU_OFF_GROUP_STATUS + `TSU_OFF_GROUP_STEP * k)) begin
                            reg_rdata <= 32'(group_pulse_count[k-1]);
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin drive and interrupt outputs, all registered
    // ----------------------------------------------------------------
    // idle pins low or floating
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            charge_pulse <= 1'b0;
            pin_out <= '0;
            pin_oe_n <= '0;
            acquiring <= 1'b0;
            irq <= 1'b0;
        end else begin
            charge_pulse <= (state == TSU_HIGH) || (state == TSU_SPREAD);
            acquiring <= (state != TSU_IDLE);
            irq <= |(touch_irq_status & touch_irq_enable);
            // Channel pins drive the pulse, sampling pins float to read the capacitor
            for (int p = 0; p < PINS; p++) begin
                if (state != TSU_IDLE && state != TSU_WAIT_SYNC && pin_channel_control[p]) begin
                    pin_out[p] <= (state == TSU_HIGH) || (state == TSU_SPREAD);
                    pin_oe_n[p] <= 1'b0;
                end else if (state != TSU_IDLE && state != TSU_WAIT_SYNC && pin_sampling_control[p]) begin
                    pin_out[p] <= 1'b0;
                    pin_oe_n[p] <= 1'b1;
                end else begin
                    pin_out[p] <= 1'b0;
                    pin_oe_n[p] <= idle_pin_state;
                end
            end
        end
    end

endmodule : tsu_touch_control

// ---- tsu_cfg.svh ----
// Register offsets, field positions, reset values and timing constants of the touch sense unit
`ifndef TSU_CFG_SVH
`define TSU_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSU_OFF_CONTROL 8'h00
`define TSU_OFF_IRQ_ENABLE 8'h04
`define TSU_OFF_FLAG_CLEAR 8'h08
`define TSU_OFF_IRQ_STATUS 8'h0C
`define TSU_OFF_HYSTERESIS 8'h10
`define TSU_OFF_ANALOG_SWITCH 8'h18
`define TSU_OFF_SAMPLING 8'h20
`define TSU_OFF_CHANNEL 8'h28
`define TSU_OFF_GROUP_STATUS 8'h30
`define TSU_OFF_GROUP_STEP 8'h04

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define TSU_BIT_ENABLE 0
`define TSU_BIT_START 1
`define TSU_BIT_MODE 2
`define TSU_BIT_POLARITY 3
`define TSU_BIT_IDLE 4
`define TSU_LIMIT_LSB 5
`define TSU_LIMIT_MSB 7
`define TSU_PDIV_LSB 12
`define TSU_PDIV_MSB 14
`define TSU_BIT_SDIV 15
`define TSU_BIT_SPREAD 16
`define TSU_DEV_LSB 17
`define TSU_DEV_MSB 23
`define TSU_LOW_LSB 24
`define TSU_LOW_MSB 27
`define TSU_HIGH_LSB 28
`define TSU_HIGH_MSB 31

// ----------------------------------------------------------------
// Status bits, reset values, masks
// ----------------------------------------------------------------
`define TSU_BIT_DONE 0
`define TSU_BIT_OVF 1
`define TSU_CONTROL_MASK 32'hFFFF_F0FF
`define TSU_PIN_MASK 32'h00FF_FFFF
`define TSU_RST_HYSTERESIS 32'hFFFF_FFFF
`define TSU_RST_ZERO 32'h0000_0000
`define TSU_LIMIT_RESERVED 3'h7
`define TSU_LFSR_SEED 16'hACE1
`define TSU_LFSR_TAPS 16'hB400

`endif

// ---- tsu_pkg.sv ----
// Types shared by the touch sense unit
package tsu_pkg;
    // Acquisition sequencer states, one-hot
    typedef enum logic [4:0] {
        TSU_IDLE = 5'b00001,
        TSU_WAIT_SYNC = 5'b00010,
        TSU_HIGH = 5'b00100,
        TSU_SPREAD = 5'b01000,
        TSU_LOW = 5'b10000
    } tsu_state_t;
endpackage : tsu_pkg

// ---- tsu_touch_control_chk.sv ----
// Port-level assertions for the touch sense unit
`timescale 1ns/1ps
`include "tsu_cfg.svh"

module tsu_touch_control_chk #(
    parameter int GROUPS = 6,
    parameter int PINS = 24
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Sync and thresholds
    input wire logic sync_in,
    input wire logic [GROUPS-1:0] group_threshold,
    // Pins and status
    input wire logic charge_pulse,
    input wire logic [PINS-1:0] pin_out,
    input wire logic [PINS-1:0] pin_oe_n,
    input wire logic acquiring,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Assertions, one clock domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_end_quiet: assert property ($fell(acquiring) |-> !charge_pulse [*3])
        else $error("charge pulse after acquisition end");
    a_pins_uniform: assert property (!acquiring && !$past(acquiring) |-> (&pin_oe_n || !(|pin_oe_n)))
        else $error("idle pins not in one state");
    a_pins_low_idle: assert property (!acquiring && !$past(acquiring) |-> pin_out == '0)
        else $error("idle pin output not low");
    a_unmapped_zero: assert property (reg_read && reg_addr == 8'h14 |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_clear_reads_zero: assert property (reg_read && reg_addr == `TSU_OFF_FLAG_CLEAR |=> reg_rdata == 32'h0)
        else $error("flag clear read not zero");
    a_ctrl_reserved: assert property (reg_read && reg_addr == `TSU_OFF_CONTROL |=> reg_rdata[11:8] == 4'h0)
        else $error("reserved control bits set");
    a_status_bits: assert property (reg_read && reg_addr == `TSU_OFF_IRQ_STATUS |=> reg_rdata[31:2] == 30'h0)
        else $error("status reserved bits set");
    a_irq_fall: assert property ($fell(irq) |-> ($past(reg_read, 2) && $past(reg_addr, 2) == 8'h0C)
        || $past(reg_write, 2)) else $error("interrupt dropped without software");
    a_start_from_write: assert property ($rose(acquiring) |->
        $past(reg_write, 3) && $past(reg_addr, 3) == 8'h00) else $error("acquisition without start");
endmodule : tsu_touch_control_chk

bind tsu_touch_control tsu_touch_control_chk #(.GROUPS(GROUPS), .PINS(PINS)) u_chk (.clock(clock), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .sync_in(sync_in), .group_threshold(group_threshold), .charge_pulse(charge_pulse), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .acquiring(acquiring), .irq(irq));

// ---- tsu_electrode_model.sv ----
// Electrode and sampling capacitor model that measures the charge pulses
`timescale 1ns/1ps

module tsu_electrode_model #(
    parameter int GROUPS = 6
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // From the unit and the bench
    input wire logic charge_pulse,
    input wire logic acquiring,
    input wire logic [15:0] need,
    input wire logic clr,
    // Threshold and measurements
    output logic [GROUPS-1:0] group_threshold,
    output logic [15:0] pulses,
    output logic [15:0] hi_min,
    output logic [15:0] hi_max,
    output logic [15:0] lo_len
);
    logic [15:0] run;
    logic last;

    // phase lengths and pulse count; capacitor stays charged until idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n || clr) begin
            last <= 1'b0;
            run <= 16'h0000;
            pulses <= 16'h0000;
            hi_min <= 16'hFFFF;
            hi_max <= 16'h0000;
            lo_len <= 16'h0000;
            group_threshold <= '0;
        end else begin
            last <= charge_pulse;
            run <= (charge_pulse == last) ? run + 16'h0001 : 16'h0001;
            group_threshold <= {GROUPS{acquiring && pulses >= need}};
            if (charge_pulse && !last) begin
                pulses <= pulses + 16'h0001;
                if (pulses != 16'h0000) lo_len <= run;
            end
            if (!charge_pulse && last) begin
                if (run < hi_min) hi_min <= run;
                if (run > hi_max) hi_max <= run;
            end
        end
    end
endmodule : tsu_electrode_model

// ---- testbench.sv ----
// Self-checking bench for the touch sense unit registers and acquisition
`timescale 1ns/1ps

module testbench;
    logic clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, sync_in = 1'b1, clr = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, v;
    logic [5:0] group_threshold;
    logic charge_pulse, acquiring, irq;
    logic [23:0] pin_out, pin_oe_n;
    logic [15:0] need = 16'h0005, pulses, hi_min, hi_max, lo_len;
    int n_fail = 0, checked = 0, cycles = 0;
    logic [7:0] offs [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h14};

    // 200 MHz clock
    always #2.5 clock = ~clock;

    tsu_touch_control dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sync_in(sync_in),
        .group_threshold(group_threshold), .charge_pulse(charge_pulse), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .acquiring(acquiring), .irq(irq));
    tsu_electrode_model model (.clock(clock), .rst_n(rst_n), .charge_pulse(charge_pulse), .acquiring(acquiring),
        .need(need), .clr(clr), .group_threshold(group_threshold), .pulses(pulses), .hi_min(hi_min),
        .hi_max(hi_max), .lo_len(lo_len));

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    // Data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic chkrd(input logic [7:0] a, input logic [31:0] exp);
        rd(a, v);
        check(v, exp);
    endtask : chkrd

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize

    // Enable and start with the chosen fields
    function automatic logic [31:0] cw(logic [2:0] lim, logic [2:0] dv, logic sd, logic sp, logic [6:0] dev,
        logic [3:0] lo, logic [3:0] hi, logic md, logic pol);
        return {hi, lo, dev, sp, sd, dv, 4'h0, lim, 1'b0, pol, md, 2'b11};
    endfunction : cw

    task automatic start(input logic [31:0] w);
        @(posedge clock) clr <= 1'b1;
        @(posedge clock) clr <= 1'b0;
        wr(8'h00, w);
    endtask : start

    // control left alone until the sequencer is idle
    task automatic wait_idle;
        int i;
        i = 0;
        repeat (3) @(posedge clock);
        while (acquiring !== 1'b0 && i < 20000) begin
            @(posedge clock);
            i++;
        end
        check(32'(i < 20000), 32'h1);
        repeat (3) @(posedge clock);
    endtask : wait_idle

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 10; i++) chkrd(offs[i], (i == 4) ? 32'h00FF_FFFF : 32'h0);
        for (int i = 4; i < 8; i++) begin
            wr(offs[i], 32'hFFFF_FFFF);
            chkrd(offs[i], 32'h00FF_FFFF);
        end
        wr(8'h00, 32'hFFFF_FFFE);
        repeat (10) @(posedge clock);
        check(32'(acquiring), 32'h0);
        rd(8'h00, v);
        check(v & 32'hFFFF_F0FD, 32'hFFFF_F0FC);
        wr(8'h00, 32'h11);
        repeat (3) @(posedge clock);
        check(32'(pin_oe_n), 32'h00FF_FFFF);
        wr(8'h00, 32'h01);
        repeat (3) @(posedge clock);
        check(32'(pin_oe_n), 32'h0);
        wr(8'h30, 32'h3F);
        // Free run, done interrupt enabled
        wr(8'h04, 32'h1);
        start(cw(3'h0, 3'h0, 1'b0, 1'b0, 7'h0, 4'h0, 4'h0, 1'b0, 1'b0));
        wait_idle();
        check(32'(irq), 32'h1);
        chkrd(8'h0C, 32'h1);
        rd(8'h00, v);
        check(32'(v[1]), 32'h0);
        rd(8'h34, v);
        check(32'(v == 32'd4 || v == 32'd5), 32'h1);
        repeat (3) @(posedge clock);
        check(32'(irq), 32'h0);
        // Done masked off
        wr(8'h04, 32'h2);
        need <= 16'h0003;
        start(cw(3'h0, 3'h0, 1'b0, 1'b0, 7'h0, 4'h0, 4'h0, 1'b0, 1'b0));
        wait_idle();
        check(32'(irq), 32'h0);
        chkrd(8'h0C, 32'h1);
        // Overflow at each of the first limits
        wr(8'h04, 32'h3);
        need <= 16'hFFFF;
        for (int c = 0; c < 3; c++) begin
            start(cw(3'(c), 3'h0, 1'b0, 1'b0, 7'h0, 4'h0, 4'h0, 1'b0, 1'b0));
            wait_idle();
            check(32'(pulses), (32'd256 << c) - 32'd1);
            check(32'(irq), 32'h1);
            chkrd(8'h0C, 32'h3);
            check({hi_min, hi_max}, {16'd1, 16'd1});
            check(32'(lo_len), 32'd1);
            rd(8'h00, v);
            check(32'(v[1]), 32'h0);
        end
        // Divided pulse clock with spread at half rate
        start(cw(3'h0, 3'h2, 1'b1, 1'b1, 7'h3, 4'h2, 4'h1, 1'b0, 1'b0));
        wait_idle();
        check(32'(hi_min), 32'd8);
        check(32'(hi_max > 16'd8 && hi_max <= 16'd16), 32'h1);
        check(32'(lo_len), 32'd12);
        wr(8'h08, 32'h3);
        chkrd(8'h0C, 32'h0);
        // Sync gated start for both polarities
        need <= 16'h0003;
        for (int p = 0; p < 2; p++) begin
            sync_in <= (p == 0);
            start(cw(3'h0, 3'h0, 1'b0, 1'b0, 7'h0, 4'h0, 4'h0, 1'b1, 1'(p)));
            repeat (20) @(posedge clock);
            check({31'h0, acquiring}, 32'h1);
            check(32'(pulses), 32'h0);
            sync_in <= (p != 0);
            wait_idle();
            check(32'(pulses >= 16'd3), 32'h1);
            chkrd(8'h0C, 32'h1);
        end
        summarize();
    end
endmodule : testbench
